/* File: hw/rsc_pkg.sv */
// Function
// R1: power-on presets port data and direction high
// R2: reset pin low holds core in reset
// R3: pin reset only when select chooses it
// R4: wait release delay after reset ends
// R5: every reset clears program counter
// R6: 55h selects output, aah selects reset pin
// R7: bad pin select code self-resets, flags
// R8: pin select powers up as aah
// R9: all resets except watchdog timeout restore select
// R10: reset pin selection overrides other pin sharing
// R11: pin select fault flag bit 3, software clears
// R12: cause bits 7 to 4 read zero
// R13: enabled brownout low supply resets, flags
// R14: low supply must outlast filter time
// R15: 5ah enables brownout, a5h disables
// R16: bad brownout code self-resets, flags, restores
// R17: brownout control powers up as 5ah
// R18: brownout off in sleep or idle
// R19: brownout reset keeps brownout control
// R20: brownout event flag bit 2, software clears
// R21: brownout select fault flag bit 1
// R22: watchdog control fault flag bit 0
// R23: fault delay counter starts on bad code
// R24: sources merge; flags survive their reset
package rsc_pkg;
  // protected register codes
  localparam logic [7:0] RSC_PIN_SEL_GPIO = 8'h55;
  localparam logic [7:0] RSC_PIN_SEL_RESET = 8'haa;
  localparam logic [7:0] RSC_PIN_SEL_POR = RSC_PIN_SEL_RESET;
  localparam logic [7:0] RSC_BW_ENABLE = 8'h5a;
  localparam logic [7:0] RSC_BW_DISABLE = 8'ha5;
  localparam logic [7:0] RSC_BW_POR = RSC_BW_ENABLE;
  // cause flag layout
  localparam int RSC_FLAG_W = 4;
  localparam int RSC_FLAG_WDT_FAULT = 0;
  localparam int RSC_FLAG_BW_FAULT = 1;
  localparam int RSC_FLAG_BW_EVENT = 2;
  localparam int RSC_FLAG_PIN_FAULT = 3;
  localparam logic [RSC_FLAG_W-1:0] RSC_FLAGS_POR = 4'h0;
  // register byte offsets
  localparam logic [31:0] RSC_OFF_PIN_SEL = 32'h0000_0000;
  localparam logic [31:0] RSC_OFF_CAUSE = 32'h0000_0004;
  localparam logic [31:0] RSC_OFF_BW_CTRL = 32'h0000_0008;
  localparam logic [1:0] RSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] RSC_RESP_SLVERR = 2'h2;
  // timing
  localparam int RSC_CLK_MHZ = 125;
  localparam int RSC_FAULT_DELAY_NS = 1000;
  localparam int RSC_RELEASE_DELAY_NS = 16000;
  localparam int RSC_FILTER_NS = 120000;
  localparam int RSC_FAULT_CYC = (RSC_FAULT_DELAY_NS * RSC_CLK_MHZ + 999) / 1000;
  localparam int RSC_RELEASE_CYC =
    (RSC_RELEASE_DELAY_NS * RSC_CLK_MHZ + 999) / 1000;
  localparam int RSC_FILTER_CYC = (RSC_FILTER_NS * RSC_CLK_MHZ + 999) / 1000;
  localparam int RSC_CNT_W = 16;
  // sequencer states
  typedef enum logic [2:0] {
    RSC_RUN = 3'h1,
    RSC_HOLD = 3'h2,
    RSC_DELAY = 3'h4
  } rsc_state_type;
  // axi4-lite carriers
  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } rsc_axi_req_type;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rsc_axi_rsp_type;
endpackage

/* File: hw/rsc_sync.sv */
`timescale 1ns/1ps
module rsc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // level in and out
  input wire logic async,
  output logic sync
);
  logic meta;

  // two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= RST_VAL;
      sync <= RST_VAL;
    end else if (ce) begin
      meta <= async;
      sync <= meta;
    end
  end
endmodule // rsc_sync

/* File: hw/rsc_timer.sv */
`timescale 1ns/1ps
module rsc_timer (
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // count while run, one pulse at limit
  input wire logic run,
  input wire logic [rsc_pkg::RSC_CNT_W-1:0] limit,
  output logic expired
);
  import rsc_pkg::*;
  logic [RSC_CNT_W-1:0] cnt;

  // saturating counter, cleared when run drops
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= '0;
    end else if (ce) begin
      if (!run) begin
        cnt <= '0;
      end else if (cnt != limit) begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  // single pulse limit edges after run rose
  always_ff @(posedge clk) begin
    if (rst) begin
      expired <= 1'b0;
    end else if (ce) begin
      expired <= run && (cnt == limit - 1'b1);
    end
  end
endmodule // rsc_timer

/* File: hw/rsc_top.sv */
`timescale 1ns/1ps
module rsc_top #(
  parameter int unsigned FAULT_CYC = rsc_pkg::RSC_FAULT_CYC,
  parameter int unsigned RELEASE_CYC = rsc_pkg::RSC_RELEASE_CYC,
  parameter int unsigned FILTER_CYC = rsc_pkg::RSC_FILTER_CYC
) (
  // clock, power-on reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // register bus
  input rsc_pkg::rsc_axi_req_type axiReq,
  output rsc_pkg::rsc_axi_rsp_type axiRsp,
  // pins and supply monitor
  input wire logic extResetPin_n,
  input wire logic supplyLow,
  // core and watchdog side
  input wire logic sleepMode,
  input wire logic wdtCtrlFault,
  input wire logic wdtTimeout,
  // reset and pin control outputs
  output logic coreHold,
  output logic pcClear,
  output logic portPreset,
  output logic sharedPinOutputEnable,
  output logic resetPinSelected,
  output logic brownoutEnable
);
  import rsc_pkg::*;

  logic [7:0] pinSel;
  logic [7:0] bwCtrl;
  logic [RSC_FLAG_W-1:0] causeFlags;
  logic [RSC_FLAG_W-1:0] flagSet;
  logic [RSC_FLAG_W-1:0] flagClr;
  rsc_state_type state;
  rsc_state_type next_state;
  logic extSync_n, supLowSync;
  logic extLowReq, bwArm, pinBad, bwBad;
  logic pinFaultFire, bwFaultFire, bwFire, relDone;
  logic anyPulse, nonWarm, relRun, enterReset;
  logic awRdy, wRdy, bValid, arRdy, rValid;
  logic [31:0] awAddr, wData, rData;
  logic [3:0] wStrb;
  logic [1:0] bResp, rResp;
  logic doWrite, wrPin, wrCause, wrBw;

  // pin and monitor levels cross into the core clock
  rsc_sync #(.RST_VAL(1'b1)) u_ext_sync (
    .clk(core_clk),
    .rst(rst),
    .ce(ce),
    .async(extResetPin_n),
    .sync(extSync_n)
  );
  rsc_sync #(.RST_VAL(1'b0)) u_sup_sync (
    .clk(core_clk),
    .rst(rst),
    .ce(ce),
    .async(supplyLow),
    .sync(supLowSync)
  );

  // request decode
  assign extLowReq = (pinSel == RSC_PIN_SEL_RESET) && !extSync_n; // [R2] [R3]
  assign bwArm = (bwCtrl == RSC_BW_ENABLE) && !sleepMode; // [R15] [R18]
  assign pinBad = (pinSel != RSC_PIN_SEL_GPIO) &&
                  (pinSel != RSC_PIN_SEL_RESET); // [R7]
  assign bwBad = (bwCtrl != RSC_BW_ENABLE) && (bwCtrl != RSC_BW_DISABLE); // [R16]

  // delay counters for faults, supply filter and release
  rsc_timer u_pin_fault (
    .clk(core_clk),
    .rst(rst),
    .ce(ce),
    .run(pinBad), // [R23]
    .limit(RSC_CNT_W'(FAULT_CYC)),
    .expired(pinFaultFire)
  );
  rsc_timer u_bw_fault (
    .clk(core_clk),
    .rst(rst),
    .ce(ce),
    .run(bwBad), // [R23]
    .limit(RSC_CNT_W'(FAULT_CYC)),
    .expired(bwFaultFire)
  );
  rsc_timer u_bw_filter (
    .clk(core_clk),
    .rst(rst),
    .ce(ce),
    .run(bwArm && supLowSync), // [R13] [R14]
    .limit(RSC_CNT_W'(FILTER_CYC)),
    .expired(bwFire)
  );
  rsc_timer u_release (
    .clk(core_clk),
    .rst(rst),
    .ce(ce),
    .run(relRun), // [R4]
    .limit(RSC_CNT_W'(RELEASE_CYC)),
    .expired(relDone)
  );

  // all sources but the reset pin merge into one reset request
  assign nonWarm = pinFaultFire || bwFaultFire || bwFire || wdtCtrlFault;
  assign anyPulse = nonWarm || wdtTimeout; // [R24]
  assign relRun = (state == RSC_DELAY) && !anyPulse && !extLowReq;
  assign enterReset = (state == RSC_RUN) && (next_state != RSC_RUN);

  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      RSC_RUN: begin
        if (extLowReq) begin
          next_state = RSC_HOLD; // [R2]
        end else if (anyPulse) begin
          next_state = RSC_DELAY;
        end
      end
      RSC_HOLD: begin
        if (!extLowReq) begin
          next_state = RSC_DELAY; // [R4]
        end
      end
      RSC_DELAY: begin
        if (extLowReq) begin
          next_state = RSC_HOLD;
        end else if (!anyPulse && relDone) begin
          next_state = RSC_RUN; // [R4]
        end
      end
      default: next_state = RSC_DELAY;
    endcase
  end

  // sequencer state and core reset outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= RSC_DELAY;
      coreHold <= 1'b1;
      pcClear <= 1'b1;
    end else if (ce) begin
      state <= next_state;
      coreHold <= (next_state != RSC_RUN);
      pcClear <= enterReset; // [R5]
    end
  end

  // port preset: power-on and every reset entered from run but watchdog timeout
  always_ff @(posedge core_clk) begin
    if (rst) begin
      portPreset <= 1'b1; // [R1]
    end else if (ce) begin
      if (enterReset && (extLowReq || nonWarm)) begin
        portPreset <= 1'b1;
      end else if (next_state == RSC_RUN) begin
        portPreset <= 1'b0;
      end
    end
  end

  // pin mux and monitor control outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sharedPinOutputEnable <= 1'b0;
      resetPinSelected <= 1'b1;
      brownoutEnable <= 1'b0;
    end else if (ce) begin
      sharedPinOutputEnable <= (pinSel == RSC_PIN_SEL_GPIO); // [R6]
      resetPinSelected <= (pinSel == RSC_PIN_SEL_RESET); // [R10]
      brownoutEnable <= bwArm; // [R18]
    end
  end

  // pin select register, restored by all but warm reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pinSel <= RSC_PIN_SEL_POR; // [R8]
    end else if (ce) begin
      if (extLowReq || nonWarm) begin
        pinSel <= RSC_PIN_SEL_POR; // [R9]
      end else if (wrPin) begin
        pinSel <= wData[7:0];
      end
    end
  end

  // brownout control, restored only on its own fault
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bwCtrl <= RSC_BW_POR; // [R17]
    end else if (ce) begin
      if (bwFaultFire) begin
        bwCtrl <= RSC_BW_POR; // [R16]
      end else if (wrBw) begin
        bwCtrl <= wData[7:0]; // [R19]
      end
    end
  end

  // cause flag sources; software writes zero to clear
  always_comb begin
    flagSet = '0;
    flagSet[RSC_FLAG_PIN_FAULT] = pinFaultFire; // [R11]
    flagSet[RSC_FLAG_BW_EVENT] = bwFire; // [R20]
    flagSet[RSC_FLAG_BW_FAULT] = bwFaultFire; // [R21]
    flagSet[RSC_FLAG_WDT_FAULT] = wdtCtrlFault; // [R22]
  end

  // sticky flags, set wins, untouched by internal reset
  for (genvar i = 0; i < RSC_FLAG_W; i++) begin : g_flag
    assign flagClr[i] = wrCause && !wData[i];
    always_ff @(posedge core_clk) begin
      if (rst) begin
        causeFlags[i] <= RSC_FLAGS_POR[i];
      end else if (ce) begin
        causeFlags[i] <= flagSet[i] || (causeFlags[i] && !flagClr[i]); // [R24]
      end
    end
  end

  // write decode, byte lane 0 carries the register
  assign doWrite = !awRdy && !wRdy && !bValid;
  assign wrPin = doWrite && wStrb[0] && (awAddr == RSC_OFF_PIN_SEL);
  assign wrCause = doWrite && wStrb[0] && (awAddr == RSC_OFF_CAUSE);
  assign wrBw = doWrite && wStrb[0] && (awAddr == RSC_OFF_BW_CTRL);

  // write address and data channels, taken in any order
  always_ff @(posedge core_clk) begin
    if (rst) begin
      awRdy <= 1'b1;
      wRdy <= 1'b1;
      awAddr <= '0;
      wData <= '0;
      wStrb <= '0;
    end else if (ce) begin
      if (awRdy && axiReq.awvalid) begin
        awRdy <= 1'b0;
        awAddr <= axiReq.awaddr;
      end else if (bValid && axiReq.bready) begin
        awRdy <= 1'b1;
      end
      if (wRdy && axiReq.wvalid) begin
        wRdy <= 1'b0;
        wData <= axiReq.wdata;
        wStrb <= axiReq.wstrb;
      end else if (bValid && axiReq.bready) begin
        wRdy <= 1'b1;
      end
    end
  end

  // write response once both halves are in
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bValid <= 1'b0;
      bResp <= RSC_RESP_OKAY;
    end else if (ce) begin
      if (doWrite) begin
        bValid <= 1'b1;
        bResp <= (wrPin || wrCause || wrBw ||
                  awAddr == RSC_OFF_PIN_SEL || awAddr == RSC_OFF_CAUSE ||
                  awAddr == RSC_OFF_BW_CTRL) ? RSC_RESP_OKAY : RSC_RESP_SLVERR;
      end else if (bValid && axiReq.bready) begin
        bValid <= 1'b0;
      end
    end
  end

  // read channel, one cycle to data
  always_ff @(posedge core_clk) begin
    if (rst) begin
      arRdy <= 1'b1;
      rValid <= 1'b0;
      rData <= '0;
      rResp <= RSC_RESP_OKAY;
    end else if (ce) begin
      if (arRdy && axiReq.arvalid) begin
        arRdy <= 1'b0;
        rValid <= 1'b1;
        rResp <= RSC_RESP_OKAY;
        rData <= '0;
        case (axiReq.araddr)
          RSC_OFF_PIN_SEL: rData[7:0] <= pinSel;
          RSC_OFF_CAUSE: rData[RSC_FLAG_W-1:0] <= causeFlags; // [R12]
          RSC_OFF_BW_CTRL: rData[7:0] <= bwCtrl;
          default: rResp <= RSC_RESP_SLVERR;
        endcase
      end else if (rValid && axiReq.rready) begin
        rValid <= 1'b0;
        arRdy <= 1'b1;
      end
    end
  end

  // bus answer straight from flops
  assign axiRsp.awready = awRdy;
  assign axiRsp.wready = wRdy;
  assign axiRsp.bvalid = bValid;
  assign axiRsp.bresp = bResp;
  assign axiRsp.arready = arRdy;
  assign axiRsp.rvalid = rValid;
  assign axiRsp.rdata = rData;
  assign axiRsp.rresp = rResp;

  // checks
  a_pinsel_por: assert property ( // [R8]
    @(posedge core_clk) rst |=> pinSel == RSC_PIN_SEL_POR)
    else $error("pin select not aah after power-on");
  a_bwctl_por: assert property ( // [R17]
    @(posedge core_clk) rst |=> bwCtrl == RSC_BW_POR)
    else $error("brownout control not 5ah after power-on");
  a_pin_oe: assert property ( // [R6]
    @(posedge core_clk) disable iff (rst)
    ce && pinSel == RSC_PIN_SEL_RESET |=> !sharedPinOutputEnable)
    else $error("output enable set with reset pin selected");
  a_ext_hold: assert property ( // [R2]
    @(posedge core_clk) disable iff (rst)
    ce && extLowReq |=> coreHold && state == RSC_HOLD)
    else $error("reset pin low without core hold");
  a_ext_gated: assert property ( // [R3]
    @(posedge core_clk) disable iff (rst)
    ce && state == RSC_RUN && pinSel != RSC_PIN_SEL_RESET && !anyPulse
    |=> !coreHold)
    else $error("reset taken with reset pin not selected");
  a_pin_fault: assert property ( // [R7]
    @(posedge core_clk) disable iff (rst)
    ce && pinFaultFire |=> causeFlags[RSC_FLAG_PIN_FAULT] && coreHold
      && pinSel == RSC_PIN_SEL_POR)
    else $error("pin select fault not handled");
  a_bw_fault: assert property ( // [R16]
    @(posedge core_clk) disable iff (rst)
    ce && bwFaultFire |=> causeFlags[RSC_FLAG_BW_FAULT] && coreHold
      && bwCtrl == RSC_BW_POR)
    else $error("brownout select fault not handled");
  a_bw_event: assert property ( // [R13]
    @(posedge core_clk) disable iff (rst)
    ce && bwFire |=> causeFlags[RSC_FLAG_BW_EVENT] && coreHold)
    else $error("brownout event not flagged");
  a_bw_keep: assert property ( // [R19]
    @(posedge core_clk) disable iff (rst)
    ce && bwFire && !bwFaultFire && !wrBw |=> bwCtrl == $past(bwCtrl))
    else $error("brownout reset changed brownout control");
  a_sleep_off: assert property ( // [R18]
    @(posedge core_clk) disable iff (rst)
    ce && sleepMode |=> !brownoutEnable)
    else $error("brownout armed in sleep");
  a_read_zero: assert property ( // [R12]
    @(posedge core_clk) disable iff (rst)
    ce && arRdy && axiReq.arvalid && axiReq.araddr == RSC_OFF_CAUSE
    |=> rData[31:RSC_FLAG_W] == '0)
    else $error("upper cause bits not zero");
  a_pc_clear: assert property ( // [R5]
    @(posedge core_clk) disable iff (rst)
    $rose(coreHold) |-> pcClear)
    else $error("reset entered without pc clear");
endmodule // rsc_top

/* File: tb/rsc_far_side.sv */
`timescale 1ns/1ps
module rsc_far_side (
  // clock and requests from the bench
  input wire logic core_clk,
  input wire logic pullLow,
  input wire logic dropSupply,
  // reset pin and supply monitor outputs
  output logic extResetPin_n,
  output logic supplyLow
);
  // pin idles high through its pull-up, comparator idles quiet
  initial begin
    extResetPin_n = 1'b1;
    supplyLow = 1'b0;
  end

  // pin pulled low while asked, released to the pull-up
  always @(posedge core_clk) begin
    extResetPin_n <= ~pullLow;
  end

  // supply episode length set by how long the bench asks
  always @(posedge core_clk) begin
    supplyLow <= dropSupply;
  end
endmodule // rsc_far_side

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import rsc_pkg::*;
  localparam int REL_N = 8;
  logic core_clk, rst, ce, sleepMode, wdtCtrlFault, wdtTimeout;
  logic extResetPin_n, supplyLow, pinLowReq, dropSupply;
  logic coreHold, pcClear, portPreset, sharedPinOutputEnable;
  logic resetPinSelected, brownoutEnable;
  rsc_axi_req_type axiReq;
  rsc_axi_rsp_type axiRsp;
  logic [33:0] expQ[$];
  logic [33:0] note;
  int failures, cmpCount, pcCount, n, p;

  rsc_top #(.FAULT_CYC(4), .RELEASE_CYC(REL_N), .FILTER_CYC(6)) i_dut (
    .core_clk(core_clk), .rst(rst), .ce(ce), .axiReq(axiReq),
    .axiRsp(axiRsp), .extResetPin_n(extResetPin_n), .supplyLow(supplyLow),
    .sleepMode(sleepMode), .wdtCtrlFault(wdtCtrlFault),
    .wdtTimeout(wdtTimeout), .coreHold(coreHold), .pcClear(pcClear),
    .portPreset(portPreset), .sharedPinOutputEnable(sharedPinOutputEnable),
    .resetPinSelected(resetPinSelected), .brownoutEnable(brownoutEnable));

  rsc_far_side i_far (.core_clk(core_clk), .pullLow(pinLowReq),
    .dropSupply(dropSupply), .extResetPin_n(extResetPin_n),
    .supplyLow(supplyLow));

  // clock
  always #4 core_clk = ~core_clk;

  // closing verdict
  task automatic report_and_stop;
    $display("failures %0d compares %0d", failures, cmpCount);
    if (failures == 0 && cmpCount > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // bus write, answer noted for the monitor
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    expQ.push_back({r, 32'h0});
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hf;
    axiReq.bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (axiReq.awvalid && axiRsp.awready === 1'b1) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready === 1'b1) axiReq.wvalid <= 1'b0;
    end while (axiRsp.bvalid !== 1'b1);
    axiReq.bready <= 1'b0;
    @(posedge core_clk); // edge passes before a next call re-raises
  endtask

  // bus read, expected data noted for the monitor
  task automatic rd(input logic [31:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    expQ.push_back({r, d});
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    do @(posedge core_clk); while (axiRsp.arready !== 1'b1);
    axiReq.arvalid <= 1'b0;
    do @(posedge core_clk); while (axiRsp.rvalid !== 1'b1);
    axiReq.rready <= 1'b0;
    @(posedge core_clk); // edge passes before a next call re-raises
  endtask

  // answers taken off the note queue in order
  always @(posedge core_clk) begin
    if ((axiRsp.rvalid === 1'b1 && axiReq.rready) ||
        (axiRsp.bvalid === 1'b1 && axiReq.bready)) begin
      if (expQ.size() == 0) begin
        failures++;
        $display("CHECK FAILED at %0t: answer without note", $time);
      end else begin
        note = expQ.pop_front();
        if (axiRsp.rvalid === 1'b1) begin
          check(axiRsp.rdata, note[31:0]);
          check({30'h0, axiRsp.rresp}, {30'h0, note[33:32]});
        end else begin
          check({30'h0, axiRsp.bresp}, {30'h0, note[33:32]});
        end
      end
    end
  end

  // count reset entries outside power-on reset
  always @(posedge core_clk) begin
    if (pcClear === 1'b1 && !rst) pcCount++;
  end

  // bounded wait for a hold level
  task automatic wait_hold(input logic lvl, input int lim, output int k);
    k = 0;
    while (coreHold !== lvl && k < lim) begin
      @(posedge core_clk);
      k++;
    end
    check({31'h0, coreHold}, {31'h0, lvl});
  endtask

  // random code outside the two valid ones
  function automatic logic [7:0] bad_code(input logic [7:0] a,
                                          input logic [7:0] b);
    logic [7:0] c;
    c = 8'($urandom);
    while (c == a || c == b) c = 8'($urandom);
    return c;
  endfunction

  // corrupt a protected register, expect self-reset, flag and restore
  task automatic fault_case(input logic [31:0] a, input logic [7:0] ok,
                            input logic [7:0] alt, input logic [31:0] flag);
    wr(a, {24'h0, bad_code(ok, alt)}, RSC_RESP_OKAY);
    wait_hold(1'b1, 30, n);
    wait_hold(1'b0, 60, n);
    rd(RSC_OFF_CAUSE, flag, RSC_RESP_OKAY);
    rd(a, {24'h0, ok}, RSC_RESP_OKAY);
    wr(RSC_OFF_CAUSE, 32'hffff_ffff, RSC_RESP_OKAY);
    rd(RSC_OFF_CAUSE, flag, RSC_RESP_OKAY);
    wr(RSC_OFF_CAUSE, 32'h0, RSC_RESP_OKAY);
    rd(RSC_OFF_CAUSE, 32'h0, RSC_RESP_OKAY);
  endtask

  // one pulse on a watchdog input, then through the reset
  task automatic wdt_pulse(input logic timeout);
    if (timeout) wdtTimeout <= 1'b1;
    else wdtCtrlFault <= 1'b1;
    @(posedge core_clk);
    wdtTimeout <= 1'b0;
    wdtCtrlFault <= 1'b0;
    wait_hold(1'b1, 10, n);
    wait_hold(1'b0, 60, n);
  endtask

  // supply dip of len cycles, expect no reset entry
  task automatic quiet_dip(input int len);
    p = pcCount;
    dropSupply <= 1'b1;
    repeat (len) @(posedge core_clk);
    dropSupply <= 1'b0;
    repeat (20) @(posedge core_clk);
    check(pcCount, p);
  endtask

  // watchdog on the whole run
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    report_and_stop();
  end

  // main sequence
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    sleepMode = 1'b0;
    wdtCtrlFault = 1'b0;
    wdtTimeout = 1'b0;
    pinLowReq = 1'b0;
    dropSupply = 1'b0;
    axiReq = '0;
    void'($urandom(49));
    repeat (3) @(posedge core_clk);
    check({31'h0, portPreset}, 32'h1);
    rst <= 1'b0;
    wait_hold(1'b0, 60, n);
    check({31'h0, n >= REL_N}, 32'h1);
    rd(RSC_OFF_PIN_SEL, 32'haa, RSC_RESP_OKAY);
    rd(RSC_OFF_CAUSE, 32'h0, RSC_RESP_OKAY);
    rd(RSC_OFF_BW_CTRL, 32'h5a, RSC_RESP_OKAY);
    check({31'h0, brownoutEnable}, 32'h1);
    // pin as output: low level must not reset
    wr(RSC_OFF_PIN_SEL, 32'h55, RSC_RESP_OKAY);
    repeat (2) @(posedge core_clk);
    check({31'h0, sharedPinOutputEnable}, 32'h1);
    check({31'h0, resetPinSelected}, 32'h0);
    p = pcCount;
    pinLowReq <= 1'b1;
    repeat (20) @(posedge core_clk);
    pinLowReq <= 1'b0;
    repeat (6) @(posedge core_clk);
    check(pcCount, p);
    wr(RSC_OFF_PIN_SEL, 32'haa, RSC_RESP_OKAY);
    repeat (2) @(posedge core_clk);
    check({31'h0, sharedPinOutputEnable}, 32'h0);
    // pin reset held low, then released
    pinLowReq <= 1'b1;
    wait_hold(1'b1, 10, n);
    check({31'h0, portPreset}, 32'h1);
    repeat (30) @(posedge core_clk);
    check({31'h0, coreHold}, 32'h1);
    pinLowReq <= 1'b0;
    wait_hold(1'b0, 40, n);
    check({31'h0, n >= REL_N}, 32'h1);
    check(pcCount, p + 1);
    fault_case(RSC_OFF_PIN_SEL, 8'haa, 8'h55, 32'h8);
    fault_case(RSC_OFF_BW_CTRL, 8'h5a, 8'ha5, 32'h2);
    // short dip ignored, long dip resets and keeps control
    quiet_dip(3);
    dropSupply <= 1'b1;
    wait_hold(1'b1, 40, n);
    dropSupply <= 1'b0;
    wait_hold(1'b0, 60, n);
    rd(RSC_OFF_CAUSE, 32'h4, RSC_RESP_OKAY);
    rd(RSC_OFF_BW_CTRL, 32'h5a, RSC_RESP_OKAY);
    wr(RSC_OFF_CAUSE, 32'h0, RSC_RESP_OKAY);
    // disabled code, then sleep, both ignore dips
    wr(RSC_OFF_BW_CTRL, 32'ha5, RSC_RESP_OKAY);
    repeat (2) @(posedge core_clk);
    check({31'h0, brownoutEnable}, 32'h0);
    quiet_dip(30);
    wr(RSC_OFF_BW_CTRL, 32'h5a, RSC_RESP_OKAY);
    sleepMode <= 1'b1;
    repeat (3) @(posedge core_clk);
    check({31'h0, brownoutEnable}, 32'h0);
    quiet_dip(30);
    sleepMode <= 1'b0;
    // warm reset keeps pin select, control fault restores it
    wr(RSC_OFF_PIN_SEL, 32'h55, RSC_RESP_OKAY);
    wdt_pulse(1'b1);
    rd(RSC_OFF_PIN_SEL, 32'h55, RSC_RESP_OKAY);
    wdt_pulse(1'b0);
    rd(RSC_OFF_PIN_SEL, 32'haa, RSC_RESP_OKAY);
    rd(RSC_OFF_CAUSE, 32'h1, RSC_RESP_OKAY);
    wr(RSC_OFF_CAUSE, 32'h0, RSC_RESP_OKAY);
    // unmapped place
    wr(32'hc, 32'h0, RSC_RESP_SLVERR);
    rd(32'hc, 32'h0, RSC_RESP_SLVERR);
    repeat (4) @(posedge core_clk);
    report_and_stop();
  end
endmodule // tb_top
